/* File: tps_host.sv */
// Host model: byte accesses on the link and a pull on the alert wire.
// Assumes the block answers each access with one RVALID pulse.
`timescale 1ns/10ps
`default_nettype none
module tps_host (
    input wire logic LINK_CLK,
    input wire logic LINK_BUSY,
    input wire logic LINK_RVALID,
    input wire logic [7:0] LINK_RDATA,
    output logic LINK_VALID,
    output logic LINK_WRITE,
    output logic [7:0] LINK_ADDR,
    output logic [7:0] LINK_WDATA,
    output logic ALERT_PULL
);
    // --------------------------------
    // Idle levels at time zero
    // --------------------------------
    initial begin
        LINK_VALID = 1'b0;
        LINK_WRITE = 1'b0;
        LINK_ADDR = 8'h00;
        LINK_WDATA = 8'h00;
        ALERT_PULL = 1'b0;
    end
    // One access; ok low when no answer came in time
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge LINK_CLK);
        LINK_VALID <= 1'b1;
        LINK_WRITE <= w;
        LINK_ADDR <= a;
        LINK_WDATA <= d;
        // Hold the request until an edge sees it taken
        do begin
            @(posedge LINK_CLK);
            n++;
        end while (LINK_BUSY !== 1'b0 && n < 20);
        LINK_VALID <= 1'b0;
        n = 0;
        while (LINK_RVALID !== 1'b1 && n < 40) begin
            @(posedge LINK_CLK);
            n++;
        end
        ok = (LINK_RVALID === 1'b1);
        q = LINK_RDATA;
        // Released lines show a changed value, not the old one
        LINK_ADDR <= ~a;
        LINK_WDATA <= ~d;
    endtask
    // Outside party drives the alert wire low for a while
    task automatic pull_alert();
        @(posedge LINK_CLK);
        ALERT_PULL <= 1'b1;
        repeat (2) @(posedge LINK_CLK);
        ALERT_PULL <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tps_pkg.sv */
// Constants for the touch power-state and status block.
// Assumes one system clock and one link clock supplied by the chip.
`default_nettype none
package tps_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h00; // Power and interrupt control
    localparam logic [7:0] ADDR_STAT_LO = 8'h03;  // Touch status low
    localparam logic [7:0] ADDR_STAT_HI = 8'h04;  // Touch status high
    localparam logic [7:0] ADDR_BUILD = 8'h05;    // Hardware build code
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_DEACTIVATE_ALL = 6; // Deactivate all
    localparam int BIT_SLEEP = 5; // Sleep
    localparam int BIT_DEEP = 4;  // Deep doze request
    localparam int BIT_PIND = 1;  // Power indicator enable
    localparam int BIT_INT = 0;   // Interrupt pending
    localparam int BIT_UP = 7;    // Slider up flag
    localparam int BIT_DOWN = 6;  // Slider down flag
    // ----------------------------------------
    // Reset values, widths, timing
    // ----------------------------------------
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [13:0] STATUS_RST = 14'h0000;
    localparam int SENSORS = 14;
    localparam int BUILD_W = 5;
    localparam logic [4:0] BUILD_CODE_DEF = 5'h03; // Value is arbitrary
    localparam int REPEAT_CYC_DEF = 1024;          // Auto-repeat period, cycles
    // Link side handshake states
    typedef enum logic {LNK_IDLE, LNK_WAIT} tps_link_t;
endpackage
`default_nettype wire

/* File: tps_top.sv */
// Power-state control and touch status registers.
// Assumes the bus engine hands over byte accesses on LINK_CLK and the
// sensing front end drives touch and slider events on CLK.
`timescale 1ns/10ps
`default_nettype none
module tps_top #(
    parameter int REPEAT_CYCLES = tps_pkg::REPEAT_CYC_DEF,
    parameter logic [4:0] BUILD_CODE = tps_pkg::BUILD_CODE_DEF
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic LINK_CLK,
    input wire logic LINK_RESET,
    input wire logic LINK_VALID,
    input wire logic LINK_WRITE,
    input wire logic [7:0] LINK_ADDR,
    input wire logic [7:0] LINK_WDATA,
    output logic LINK_BUSY,
    output logic LINK_RVALID,
    output logic [7:0] LINK_RDATA,
    input wire logic [13:0] TOUCH_PRESENT,
    input wire logic [13:0] INT_ENABLE,
    input wire logic [13:0] SLEEP_CHANNELS,
    input wire logic SLIDE_UP_EVT,
    input wire logic SLIDE_DOWN_EVT,
    input wire logic GROUP_HELD,
    input wire logic GROUP_REPEAT_EN,
    input wire logic INDICATOR_NORMAL,
    input wire logic INDICATOR_ALTERNATE,
    input wire logic ALERT_IN_N,
    output logic ALERT_OUT_N,
    output logic ALERT_OE,
    output logic [13:0] SCAN_ENABLE,
    output logic LED_ENABLE,
    output logic PWM_ENABLE,
    output logic LED_IDLE_LEVEL,
    output logic POWER_INDICATOR_OUTPUT,
    output logic GROUP_STATUS_CLEAR
);
    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    tps_pkg::tps_link_t lnk_state_r; // Handshake state
    logic req_tgl_r;                 // Request toggle to core
    logic req_wr_r;                  // Held write flag
    logic [7:0] req_addr_r;          // Held address
    logic [7:0] req_wdata_r;         // Held write data
    logic ack_s1_r;                  // Ack synchroniser stage 1
    logic ack_s2_r;                  // Ack synchroniser stage 2
    logic ack_s3_r;                  // Ack edge history
    logic busy_r;
    logic rvalid_r;
    logic [7:0] rdata_r;
    logic ack_tgl_r;                 // Core side ack toggle
    logic [7:0] core_rdata_r;        // Core read result, stable at ack

    // Ack toggle sync; stage 1 feeds only stage 2
    always_ff @(posedge LINK_CLK) begin
        if (LINK_RESET) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    // Accept one access, wait for the core, return read data
    always_ff @(posedge LINK_CLK) begin
        if (LINK_RESET) begin
            lnk_state_r <= tps_pkg::LNK_IDLE;
            req_tgl_r <= 1'b0;
            req_wr_r <= 1'b0;
            req_addr_r <= 8'h00;
            req_wdata_r <= 8'h00;
            busy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            rvalid_r <= 1'b0;
            unique case (lnk_state_r)
                tps_pkg::LNK_IDLE: begin
                    // Held words stay put until the core answers
                    if (LINK_VALID) begin
                        req_wr_r <= LINK_WRITE;
                        req_addr_r <= LINK_ADDR;
                        req_wdata_r <= LINK_WDATA;
                        req_tgl_r <= ~req_tgl_r;
                        busy_r <= 1'b1;
                        lnk_state_r <= tps_pkg::LNK_WAIT;
                    end
                end
                tps_pkg::LNK_WAIT: begin
                    if (ack_s2_r != ack_s3_r) begin
                        rdata_r <= core_rdata_r;
                        rvalid_r <= 1'b1;
                        busy_r <= 1'b0;
                        lnk_state_r <= tps_pkg::LNK_IDLE;
                    end
                end
            endcase
        end
    end

    assign LINK_BUSY = busy_r;
    assign LINK_RVALID = rvalid_r;
    assign LINK_RDATA = rdata_r;

    // ----------------------------------------
    // Core domain crossing
    // ----------------------------------------
    logic req_s1_r;
    logic req_s2_r;
    logic req_s3_r;
    logic al_s1_r; // Alert pin sync stage 1
    logic al_s2_r; // Alert pin sync stage 2
    logic oe_s1_r; // Own pull, delayed to line up with the pin sync
    logic oe_s2_r; // Own pull as seen at al_s2_r
    logic go;      // One access to execute

    // Two flops before any logic reads the request or pin
    always_ff @(posedge CLK) begin
        if (RESET) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            al_s1_r <= 1'b1;
            al_s2_r <= 1'b1;
            oe_s1_r <= 1'b0;
            oe_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            al_s1_r <= ALERT_IN_N;
            al_s2_r <= al_s1_r;
            // Same-domain delay; tells our own pull from an outside one
            oe_s1_r <= ALERT_OE;
            oe_s2_r <= oe_s1_r;
        end
    end

    assign go = req_s2_r ^ req_s3_r;

    // ----------------------------------------
    // Control and status state
    // ----------------------------------------
    logic deactivate_all_r, sleep_r, deep_r, pind_r, int_r;
    logic deactivate_all_nxt, deep_nxt, int_nxt;
    logic [13:0] status_r, status_nxt; // Sensor press bits
    logic [13:0] prev_r;               // Last scanned touches
    logic [13:0] eff_touch;            // Touches on scanned channels
    logic [13:0] press_edge;           // New enabled presses
    logic up_r, dn_r, last_up_r;
    logic up_evt, dn_evt, any_evt, scan_on, off_nxt;
    logic wr0, rd3, int_clr;
    logic rep_tick_r;
    logic [31:0] rep_cnt_r;
    logic [7:0] pwr_byte;

    // Read multiplexer; unmapped addresses answer zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] p,
                                          input logic [13:0] s, input logic u,
                                          input logic d);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            tps_pkg::ADDR_PWR_CTRL: v = p;
            tps_pkg::ADDR_STAT_LO: v = {u, d, s[5:0]};
            tps_pkg::ADDR_STAT_HI: v = s[13:6];
            tps_pkg::ADDR_BUILD: v = {3'h0, BUILD_CODE};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Reserved control bits are never stored
    assign pwr_byte = {1'b0, deactivate_all_r, sleep_r, deep_r, 2'h0, pind_r, int_r};
    assign wr0 = go & req_wr_r & (req_addr_r == tps_pkg::ADDR_PWR_CTRL);
    assign rd3 = go & ~req_wr_r & (req_addr_r == tps_pkg::ADDR_STAT_LO);
    // Writing zero is a clear even when nothing is pending
    assign int_clr = wr0 & ~req_wdata_r[tps_pkg::BIT_INT];
    assign scan_on = ~deactivate_all_r & ~deep_r;
    assign eff_touch = TOUCH_PRESENT & SCAN_ENABLE;
    // Masked channels produce no action at all
    assign press_edge = eff_touch & ~prev_r & INT_ENABLE;
    assign up_evt = SLIDE_UP_EVT & scan_on;
    assign dn_evt = SLIDE_DOWN_EVT & scan_on;
    assign any_evt = (|press_edge) | up_evt | dn_evt | rep_tick_r;

    // Power state next values
    always_comb begin
        deactivate_all_nxt = deactivate_all_r;
        deep_nxt = deep_r;
        // Only a host write changes deactivate
        if (wr0) begin
            deactivate_all_nxt = req_wdata_r[tps_pkg::BIT_DEACTIVATE_ALL];
        end
        // Any access or the alert pin wakes deep doze, except a control write that sets BIT_DEEP
        if (go && deep_r) begin
            deep_nxt = 1'b0;
        end
        // Our own pull still in the sync chain must not wake us
        if (deep_r && !al_s2_r && !oe_s2_r) begin
            deep_nxt = 1'b0;
        end
        if (wr0) begin
            deep_nxt = req_wdata_r[tps_pkg::BIT_DEEP];
        end
    end

    assign off_nxt = deactivate_all_nxt | deep_nxt;

    // Control register; reset to zero keeps scanning on
    always_ff @(posedge CLK) begin
        if (RESET) begin
            deactivate_all_r <= tps_pkg::PWR_CTRL_RST[tps_pkg::BIT_DEACTIVATE_ALL];
            sleep_r <= tps_pkg::PWR_CTRL_RST[tps_pkg::BIT_SLEEP];
            deep_r <= tps_pkg::PWR_CTRL_RST[tps_pkg::BIT_DEEP];
            pind_r <= tps_pkg::PWR_CTRL_RST[tps_pkg::BIT_PIND];
        end else begin
            deactivate_all_r <= deactivate_all_nxt;
            deep_r <= deep_nxt;
            if (wr0) begin
                sleep_r <= req_wdata_r[tps_pkg::BIT_SLEEP];
                pind_r <= req_wdata_r[tps_pkg::BIT_PIND];
            end
        end
    end

    // Pending next value; an event beats a same-cycle clear
    always_comb begin
        int_nxt = int_r;
        if (int_clr) begin
            int_nxt = 1'b0;
        end
        if (any_evt) begin
            int_nxt = 1'b1;
        end
        if (off_nxt) begin
            int_nxt = 1'b0;
        end
    end

    // Sensor status next value
    always_comb begin
        status_nxt = status_r;
        // Still-touched bits survive a clear
        if (int_clr) begin
            status_nxt = status_r & eff_touch;
        end
        status_nxt = status_nxt | press_edge;
        if (off_nxt) begin
            status_nxt = tps_pkg::STATUS_RST;
        end
    end

    // Pending bit and sensor status; sleep leaves them alone
    always_ff @(posedge CLK) begin
        if (RESET) begin
            int_r <= tps_pkg::PWR_CTRL_RST[tps_pkg::BIT_INT];
            status_r <= tps_pkg::STATUS_RST;
            prev_r <= tps_pkg::STATUS_RST;
        end else begin
            int_r <= int_nxt;
            status_r <= status_nxt;
            prev_r <= eff_touch;
        end
    end

    // Direction flags: sticky, exclusive, re-set by own events
    always_ff @(posedge CLK) begin
        if (RESET) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
            last_up_r <= 1'b0;
        end else if (off_nxt) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else if (up_evt || (rep_tick_r && last_up_r)) begin
            up_r <= 1'b1;
            dn_r <= 1'b0;
            last_up_r <= 1'b1;
        end else if (dn_evt || (rep_tick_r && !last_up_r)) begin
            dn_r <= 1'b1;
            up_r <= 1'b0;
            last_up_r <= 1'b0;
        end else if (int_clr && !GROUP_HELD) begin
            // Held slider keeps its flag through a clear
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end
    end

    // Auto-repeat timer while the slider stays held
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rep_cnt_r <= 32'h0000_0000;
            rep_tick_r <= 1'b0;
        end else begin
            rep_tick_r <= 1'b0;
            if (!(GROUP_REPEAT_EN && GROUP_HELD && scan_on)) begin
                rep_cnt_r <= 32'h0000_0000;
            end else if (rep_cnt_r == 32'(REPEAT_CYCLES - 1)) begin
                rep_cnt_r <= 32'h0000_0000;
                rep_tick_r <= 1'b1;
            end else begin
                rep_cnt_r <= rep_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Access completion: read data and ack back to the link
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ack_tgl_r <= 1'b0;
            core_rdata_r <= 8'h00;
            GROUP_STATUS_CLEAR <= 1'b0;
        end else begin
            GROUP_STATUS_CLEAR <= rd3;
            if (go) begin
                core_rdata_r <= req_wr_r ? 8'h00 :
                    rd_mux(req_addr_r, pwr_byte, status_r, up_r, dn_r);
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    // ----------------------------------------
    // Power-state outputs
    // ----------------------------------------
    // Registered decode; outputs other than ALERT_OE lag the control bits by one cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SCAN_ENABLE <= 14'h3FFF;
            LED_ENABLE <= 1'b1;
            PWM_ENABLE <= 1'b1;
            LED_IDLE_LEVEL <= 1'b0;
            POWER_INDICATOR_OUTPUT <= 1'b0;
            ALERT_OE <= 1'b0;
            ALERT_OUT_N <= 1'b0;
        end else begin
            if (deactivate_all_r || deep_r) begin
                SCAN_ENABLE <= 14'h0000;
            end else if (sleep_r) begin
                SCAN_ENABLE <= SLEEP_CHANNELS;
            end else begin
                SCAN_ENABLE <= 14'h3FFF;
            end
            LED_ENABLE <= ~(deactivate_all_r | sleep_r | deep_r);
            PWM_ENABLE <= ~(deactivate_all_r | deep_r);
            LED_IDLE_LEVEL <= deep_r;
            if (!pind_r) begin
                POWER_INDICATOR_OUTPUT <= 1'b0;
            end else if (sleep_r || deep_r) begin
                POWER_INDICATOR_OUTPUT <= INDICATOR_ALTERNATE;
            end else begin
                POWER_INDICATOR_OUTPUT <= INDICATOR_NORMAL;
            end
            // Open drain: drive low only while pending
            ALERT_OE <= int_nxt;
            ALERT_OUT_N <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    deactivate_all_scan_a: assert property (deactivate_all_r |=> SCAN_ENABLE == 14'h0000 && !LED_ENABLE)
        else $error("scan or LEDs active while deactivated");
    deactivate_all_hold_a: assert property (deactivate_all_r && !wr0 |=> deactivate_all_r)
        else $error("deactivate left without host write");
    sleep_scan_a: assert property (sleep_r && scan_on |=>
        !LED_ENABLE && SCAN_ENABLE == $past(SLEEP_CHANNELS))
        else $error("sleep scan set wrong");
    deep_pwm_a: assert property (deep_r |=> !PWM_ENABLE && LED_IDLE_LEVEL)
        else $error("PWM running in deep doze");
    pin_wake_a: assert property (deep_r && !al_s2_r && !oe_s2_r && !wr0 |=> !deep_r)
        else $error("alert pin did not wake");
    link_wake_a: assert property (go && deep_r && !wr0 |=> !deep_r)
        else $error("link access did not wake");
    off_clear_a: assert property ($rose(deep_r || deactivate_all_r) |->
        status_r == 14'h0000 && !int_r && !up_r && !dn_r)
        else $error("status kept on entering off state");
    ind_off_a: assert property (!pind_r |=> !POWER_INDICATOR_OUTPUT)
        else $error("indicator on while disabled");
    ind_alt_a: assert property (pind_r && (sleep_r || deep_r) |=>
        POWER_INDICATOR_OUTPUT == $past(INDICATOR_ALTERNATE))
        else $error("indicator not on alternate");
    int_cause_a: assert property ($rose(int_r) |-> $past(any_evt) && ALERT_OE)
        else $error("pending set without event");
    int_clear_a: assert property (int_clr && !any_evt |=> !int_r && !ALERT_OE)
        else $error("pending not cleared");
    retain_a: assert property (int_clr && !off_nxt |=>
        (status_r & $past(status_r & eff_touch)) == $past(status_r & eff_touch))
        else $error("held touch status lost");
    grp_clr_a: assert property (rd3 |=> GROUP_STATUS_CLEAR ##1 !GROUP_STATUS_CLEAR)
        else $error("group clear pulse wrong");
    dir_excl_a: assert property (!(up_r && dn_r))
        else $error("up and down both set");
    build_rd_a: assert property (go && !req_wr_r && req_addr_r == tps_pkg::ADDR_BUILD
        |=> core_rdata_r == {3'h0, BUILD_CODE})
        else $error("build read wrong");
    cv_wake_c: cover property (deep_r ##1 !deep_r);
    cv_press_c: cover property ($rose(int_r) ##[1:50] int_clr);
    cv_repeat_c: cover property (rep_tick_r ##1 up_r);
endmodule
`default_nettype wire

/* File: tps_top_test.sv */
// Self-checking bench for the power-state and status block.
// Assumes tps_host.sv is compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module tps_top_test;
    localparam logic [4:0] BCODE = 5'h16; // Value is arbitrary
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic lrst = 1'b1;
    logic [13:0] touch = 14'h0000;
    logic [13:0] inten = 14'h2001;
    logic [13:0] sleepch = 14'h0005;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic held = 1'b0;
    logic rpt = 1'b0;
    logic inorm = 1'b1;
    logic ialt = 1'b0;
    logic valid, wr, busy, rv, pull, aout_n, aoe, leden, pwm, idle, pind, gclr, alert_n;
    logic [7:0] addr, wd, rdat;
    logic [13:0] scan;
    int failures = 0;
    int n_checks = 0;
    int n_gclr = 0;
    // --------------------------------
    // Clocks, wire, monitor
    // --------------------------------
    always #2 clk = ~clk;
    initial begin
        #0.7;
        forever #32 lclk = ~lclk;
    end
    // Pull-up wire: low when either side pulls
    assign alert_n = ~((aoe & ~aout_n) | pull);
    always @(posedge clk) if (gclr === 1'b1) n_gclr++;
    tps_top #(.REPEAT_CYCLES(8), .BUILD_CODE(BCODE)) dut (.CLK(clk), .RESET(rst),
        .LINK_CLK(lclk), .LINK_RESET(lrst), .LINK_VALID(valid), .LINK_WRITE(wr),
        .LINK_ADDR(addr), .LINK_WDATA(wd), .LINK_BUSY(busy), .LINK_RVALID(rv),
        .LINK_RDATA(rdat), .TOUCH_PRESENT(touch), .INT_ENABLE(inten),
        .SLEEP_CHANNELS(sleepch), .SLIDE_UP_EVT(up), .SLIDE_DOWN_EVT(dn),
        .GROUP_HELD(held), .GROUP_REPEAT_EN(rpt), .INDICATOR_NORMAL(inorm),
        .INDICATOR_ALTERNATE(ialt), .ALERT_IN_N(alert_n), .ALERT_OUT_N(aout_n),
        .ALERT_OE(aoe), .SCAN_ENABLE(scan), .LED_ENABLE(leden), .PWM_ENABLE(pwm),
        .LED_IDLE_LEVEL(idle), .POWER_INDICATOR_OUTPUT(pind), .GROUP_STATUS_CLEAR(gclr));
    tps_host host (.LINK_CLK(lclk), .LINK_BUSY(busy), .LINK_RVALID(rv),
        .LINK_RDATA(rdat), .LINK_VALID(valid), .LINK_WRITE(wr), .LINK_ADDR(addr),
        .LINK_WDATA(wd), .ALERT_PULL(pull));
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Access; a lost answer ends the run
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic ok;
        host.xfer(w, a, d, q, ok);
        chk("answer", 16'h0001, {15'h0000, ok});
        if (ok !== 1'b1) test_done();
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
    endtask
    // Bounded wait for a level, then judged
    task automatic await(input string nm, ref logic s, input logic v);
        int n;
        for (n = 0; n < 60 && s !== v; n++) @(posedge clk);
        chk(nm, {15'h0000, v}, {15'h0000, s});
        if (s !== v) test_done();
    endtask
    task automatic pulse(input logic u);
        @(posedge clk);
        if (u) up <= 1'b1;
        else dn <= 1'b1;
        @(posedge clk);
        up <= 1'b0;
        dn <= 1'b0;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset();
        chk("scan", 16'h3FFF, {2'b00, scan});
        chk("led pwm idle ind oe out", 16'h0030, {10'h000, leden, pwm, idle, pind, aoe, aout_n});
        rdc(8'h00, 8'h00);
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h00);
        wrr(8'h05, 8'hFF);
        rdc(8'h05, {3'b000, BCODE});
        wrr(8'h07, 8'hFF);
        rdc(8'h07, 8'h00);
        wrr(8'h00, 8'h8C);
        rdc(8'h00, 8'h00);
    endtask
    // Sensors 1, 2 and 14 pressed; 2 is masked
    task automatic t_touch();
        int g;
        @(posedge clk);
        touch <= 14'h2003;
        await("alert", aoe, 1'b1);
        rdc(8'h00, 8'h01);
        g = n_gclr;
        rdc(8'h03, 8'h01);
        chk("group clear", 16'h0001, 16'(n_gclr - g));
        rdc(8'h04, 8'h80);
        @(posedge clk);
        touch <= 14'h0001;
        wrr(8'h00, 8'h00);
        await("alert", aoe, 1'b0);
        rdc(8'h03, 8'h01);
        rdc(8'h04, 8'h00);
        repeat (20) @(posedge clk);
        chk("no realert", 16'h0000, {15'h0000, aoe});
        @(posedge clk);
        touch <= 14'h0000;
        wrr(8'h00, 8'h00);
    endtask
    task automatic t_slide();
        pulse(1'b1);
        rdc(8'h03, 8'h80);
        pulse(1'b0);
        rdc(8'h03, 8'h40);
        rdc(8'h03, 8'h40);
        wrr(8'h00, 8'h00);
        rdc(8'h03, 8'h00);
        @(posedge clk);
        rpt <= 1'b1;
        held <= 1'b1;
        pulse(1'b1);
        rdc(8'h03, 8'h80);
        wrr(8'h00, 8'h00);
        await("repeat", aoe, 1'b1);
        @(posedge clk);
        held <= 1'b0;
        rpt <= 1'b0;
        wrr(8'h00, 8'h00);
        rdc(8'h03, 8'h00);
    endtask
    task automatic t_power();
        @(posedge clk);
        touch <= 14'h0001;
        await("alert", aoe, 1'b1);
        wrr(8'h00, 8'h40);
        rdc(8'h00, 8'h40);
        rdc(8'h03, 8'h00);
        chk("deactivate_all", 16'h0000, {1'b0, leden, scan});
        wrr(8'h00, 8'h00);
        chk("scan", 16'h3FFF, {2'b00, scan});
        @(posedge clk);
        touch <= 14'h0000;
        wrr(8'h00, 8'h02);
        chk("ind", 16'h0001, {15'h0000, pind});
        wrr(8'h00, 8'h22);
        chk("sleep", 16'h0005, {1'b0, leden, scan});
        chk("ind", 16'h0000, {15'h0000, pind});
        wrr(8'h00, 8'h00);
        chk("ind", 16'h0000, {15'h0000, pind});
        @(posedge clk);
        touch <= 14'h0001;
        await("alert", aoe, 1'b1);
        wrr(8'h00, 8'h12);
        chk("deep", 16'h0001, {scan, pwm, idle});
        @(posedge clk);
        touch <= 14'h0000;
        host.pull_alert();
        await("wake", pwm, 1'b1);
        wrr(8'h00, 8'h12);
        rdc(8'h05, {3'b000, BCODE});
        rdc(8'h00, 8'h02);
    endtask
    initial begin
        repeat (3) @(posedge lclk);
        lrst <= 1'b0;
        @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_touch();
        t_slide();
        t_power();
        test_done();
    end
endmodule
`default_nettype wire
